// >>> pin_load.sv
// load on the timer pin: pad level and pulse timing
// assumes sampling on the timer clock; undriven pad pulled low
`timescale 1ns/1ps
module pin_load
(
    input wire clk,
    input wire pin,
    input wire oe_n,
    output wire pad,
    output reg [15:0] high_len_ff = 16'h0000,
    output reg [15:0] rise_gap_ff = 16'h0000
);
    reg pad_ff = 1'b0;
    reg [15:0] hi_ff = 16'h0000;
    reg [15:0] gap_ff = 16'h0000;
    // pull-down, so a released pad never shows a stale level
    assign pad = oe_n ? 1'b0 : pin;
    // width of the last high pulse and spacing of rises
    always @(posedge clk)
    begin
        pad_ff <= pad;
        gap_ff <= (pad && !pad_ff) ? 16'h0001 : gap_ff + 16'h0001;
        hi_ff <= pad ? hi_ff + 16'h0001 : 16'h0000;
        if (pad && !pad_ff)
            rise_gap_ff <= gap_ff;
        if (!pad && pad_ff)
            high_len_ff <= hi_ff;
    end
endmodule

// >>> tb_top.sv
// self-checking bench for the interval / pwm timer
// assumes the register map header and the pin load model
`timescale 1ns/1ps
`include "timer_h_map.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    reg ref_clk = 1'b0;
    reg arst_n = 1'b0;
    reg losc_clk = 1'b0;
    reg cpu_wr = 1'b0;
    reg cpu_rd = 1'b0;
    reg [15:0] cpu_addr = 16'h0000;
    reg [7:0] cpu_wdata = 8'h00;
    wire [7:0] cpu_rdata;
    wire match_irq;
    wire pin;
    wire pin_oe_n;
    wire [7:0] count_value;
    wire pad;
    wire [15:0] high_len;
    wire [15:0] rise_gap;
    int num_errors = 0;
    int samples_checked = 0;
    int n;
    // slow oscillator: ten timer clocks per period, offset phase
    always #20 ref_clk = ~ref_clk;
    initial #13 forever #200 losc_clk = ~losc_clk;
    timer_h i_dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .LOSC_CLK(losc_clk),
        .CPU_WR(cpu_wr), .CPU_RD(cpu_rd), .CPU_ADDR(cpu_addr), .CPU_WDATA(cpu_wdata),
        .CPU_RDATA(cpu_rdata), .MATCH_IRQ(match_irq), .TIMER_OUT_PIN(pin),
        .TIMER_OUT_PIN_OE_N(pin_oe_n), .COUNT_VALUE(count_value));
    pin_load i_load (.clk(ref_clk), .pin(pin), .oe_n(pin_oe_n), .pad(pad),
        .high_len_ff(high_len), .rise_gap_ff(rise_gap));
    // ----
    // bus and wait helpers
    // ----
    task automatic wr(input [15:0] a, input [7:0] d);
        @(negedge ref_clk);
        cpu_wr = 1'b1;
        cpu_addr = a;
        cpu_wdata = d;
        @(negedge ref_clk);
        cpu_wr = 1'b0;
    endtask
    task automatic rd(input [15:0] a, input [7:0] e, input string nm);
        @(negedge ref_clk);
        cpu_rd = 1'b1;
        cpu_addr = a;
        @(negedge ref_clk);
        cpu_rd = 1'b0;
        `CHK(nm, e, cpu_rdata)
    endtask
    // bounded wait; n ends at lim when no irq came
    task automatic wait_irq(input int lim);
        n = 0;
        while (match_irq !== 1'b1 && n < lim)
        begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    task automatic irq_gap(input int lim);
        wait_irq(lim);
        @(negedge ref_clk);
        wait_irq(lim);
        n++;
    endtask
    // pulse width is latched one clock after the pad falls
    task automatic fall_chk(input [15:0] e);
        @(negedge pad);
        repeat (2) @(negedge ref_clk);
        `CHK("pulse high", e, high_len)
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset;
        `CHK("oe_n", 1'b1, pin_oe_n)
        rd(`OFS_TIMER_MODE, 8'h00, "mode");
        rd(`OFS_PERIOD_COMPARE, 8'h00, "period");
        rd(`OFS_DUTY_COMPARE, 8'h00, "duty");
        rd(`OFS_PORT4_DIRECTION, 8'hFF, "dir");
        wr(`OFS_PORT4_DIRECTION, 8'h00);
        wr(`OFS_PORT4_LATCH, 8'h00);
        rd(`OFS_PORT4_DIRECTION, 8'hC0, "dir fixed");
        rd(16'hFF7F, 8'h00, "unmapped");
        `CHK("oe_n on", 1'b0, pin_oe_n)
    endtask
    task automatic t_interval;
        wr(`OFS_DUTY_COMPARE, 8'h01);
        wr(`OFS_PERIOD_COMPARE, 8'h04);
        wr(`OFS_TIMER_MODE, 8'h01);
        wr(`OFS_TIMER_MODE, 8'h81);
        wait_irq(20);
        `CHK("first irq", 1'b1, n < 8)
        irq_gap(20);
        `CHK("interval", 6, n + 1)
        repeat (12) @(negedge ref_clk);
        `CHK("square high", 16'h0005, high_len)
        `CHK("square period", 16'h000A, rise_gap)
        wr(`OFS_TIMER_MODE, 8'h83);
        wr(`OFS_TIMER_MODE, 8'h03);
        repeat (3) @(negedge ref_clk);
        `CHK("stop count", 8'h00, count_value)
        `CHK("stop pin", 1'b0, pin)
        rd(`OFS_TIMER_MODE, 8'h01, "mode locked");
    endtask
    task automatic t_clock_select;
        int div [5] = '{1, 4, 16, 64, 4096};
        wr(`OFS_PERIOD_COMPARE, 8'h01);
        for (int c = 0; c < 7; c++)
        begin
            wr(`OFS_TIMER_MODE, {1'b0, c[2:0], 4'h0});
            wr(`OFS_TIMER_MODE, {1'b1, c[2:0], 4'h0});
            irq_gap(9000);
            if (c < 5)
                `CHK("tick rate", 2 * div[c], n)
            else if (c == 5)
                `CHK("slow rate", 1'b1, n > 2558 && n < 2562)
            else
                `CHK("no ticks", 9001, n)
        end
        wr(`OFS_TIMER_MODE, 8'h00);
    endtask
    task automatic t_pwm;
        wr(`OFS_PERIOD_COMPARE, 8'h07);
        wr(`OFS_DUTY_COMPARE, 8'h02);
        wr(`OFS_TIMER_MODE, 8'h09);
        wr(`OFS_TIMER_MODE, 8'h89);
        irq_gap(30);
        `CHK("pwm period", 8, n)
        wait_irq(30);
        wr(`OFS_DUTY_COMPARE, 8'h05);
        fall_chk(16'h0003);
        fall_chk(16'h0006);
        `CHK("pwm cycle", 16'h0008, rise_gap)
        rd(`OFS_DUTY_COMPARE, 8'h05, "duty readback");
        wait_irq(30);
        repeat (4) @(negedge ref_clk);
        wr(`OFS_DUTY_COMPARE, 8'h03);
        fall_chk(16'h0006);
        fall_chk(16'h0006);
        fall_chk(16'h0004);
        wr(`OFS_TIMER_MODE, 8'h09);
    endtask
    task automatic end_sim;
        if (num_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(negedge ref_clk);
        arst_n = 1'b1;
        t_reset;
        t_interval;
        t_clock_select;
        t_pwm;
        end_sim;
    end
    // watchdog: the whole run needs well under 60000 clocks
    initial
    begin
        #(40 * 80000);
        num_errors++;
        end_sim;
    end
endmodule

// >>> timer_h.v
// 8-bit timer with period and duty compare: interval, square wave and pwm output
// assumes a simple synchronous cpu register port on REF_CLK; LOSC_CLK is a slow
// oscillator level from another domain and is synchronised here
//
// Functional notes
// - interval mode: period match raises interrupt, clears counter, counting continues
// - run bit 7 low stops and zeroes counter; high counts
// - bits 6:4 pick count clock; codes above 101 prohibited
// - bits 3:2 pick interval (00) or pwm (10) mode
// - bit 1 sets the default output level
// - bit 0 enables pin output; interval mode gives 50% square wave
// - interval mode ignores the duty compare register entirely
// - interval match inverts output, clears counter, pulses interrupt
// - interrupts repeat every period plus one count clocks while running
// - counting begins within one count clock after run set
// - clearing run forces interrupt and output inactive
// - duty write during counting applies at next match with old duty
// - duty write colliding with old match defers to following match
// - reset clears period, duty and mode registers
// - port4 direction: 0 output, 1 input; resets FFH, bits 7:6 stay 1
// - pwm: period match clears, interrupts, goes active; duty match goes inactive
`timescale 1ns/1ps
`include "timer_h_map.vh"

module timer_h
(
    input wire REF_CLK,
    input wire ARST_N,
    input wire LOSC_CLK,
    input wire CPU_WR,
    input wire CPU_RD,
    input wire [15:0] CPU_ADDR,
    input wire [7:0] CPU_WDATA,
    output reg [7:0] CPU_RDATA,
    output reg MATCH_IRQ,
    output reg TIMER_OUT_PIN,
    output reg TIMER_OUT_PIN_OE_N,
    output reg [7:0] COUNT_VALUE
)
;
    // ------------------------------------------------------------
    // pwm compare phase states
    // ------------------------------------------------------------
    localparam ST_PERIOD = 2'b01;
    localparam ST_DUTY = 2'b10;

    reg [7:0] mode_ff;
    reg [7:0] period_ff;
    reg [7:0] duty_ff;
    reg [7:0] duty_buf_ff;
    reg duty_pend_ff;
    reg [7:0] dir_ff;
    reg [7:0] latch_ff;
    reg [7:0] cnt_ff;
    reg [1:0] st_ff;
    reg tout_ff;
    reg losc_s1_ff;
    reg losc_s2_ff;
    reg [7:0] nxt_rdata;
    wire tick;
    wire run;
    wire pwm;
    wire out_lvl;
    wire per_match;
    wire duty_match;
    wire wr_mode;
    wire wr_period;
    wire wr_duty;
    wire wr_dir;
    wire wr_latch;
    wire pin_level;
    wire pin_oe_n;

    assign run = mode_ff[`MODE_RUN_BIT];
    assign pwm = (mode_ff[`MODE_MD_HI:`MODE_MD_LO] == `MD_PWM);
    assign wr_mode = CPU_WR && (CPU_ADDR == `OFS_TIMER_MODE);
    assign wr_period = CPU_WR && (CPU_ADDR == `OFS_PERIOD_COMPARE);
    assign wr_duty = CPU_WR && (CPU_ADDR == `OFS_DUTY_COMPARE);
    assign wr_dir = CPU_WR && (CPU_ADDR == `OFS_PORT4_DIRECTION);
    assign wr_latch = CPU_WR && (CPU_ADDR == `OFS_PORT4_LATCH);

    // ------------------------------------------------------------
    // low-speed oscillator synchroniser
    // ------------------------------------------------------------
    always @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            losc_s1_ff <= 1'b0;
            losc_s2_ff <= 1'b0;
        end
        else
        begin
            losc_s1_ff <= LOSC_CLK;
            losc_s2_ff <= losc_s1_ff;
        end
    end

    // count clock generation
    timer_h_prescaler u_pre
    (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .run(run),
        .clk_sel(mode_ff[`MODE_CKS_HI:`MODE_CKS_LO]),
        .losc_sync(losc_s2_ff),
        .tick_ff(tick)
    );

    // ------------------------------------------------------------
    // compare logic
    // ------------------------------------------------------------
    // duty compare only looked at in the pwm duty phase
    assign per_match = run && tick && (cnt_ff == period_ff) && (!pwm || st_ff == ST_PERIOD);
    assign duty_match = run && tick && pwm && (st_ff == ST_DUTY) && (cnt_ff == duty_ff);

    // ------------------------------------------------------------
    // cpu register writes
    // ------------------------------------------------------------
    // mode and compares clear on reset port4 top bits pinned high
    always @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            mode_ff <= `RST_MODE;
            period_ff <= `RST_PERIOD;
            dir_ff <= `RST_PORT4_DIR;
            latch_ff <= `RST_PORT4_LATCH;
        end
        else
        begin
            // while running only the run bit is honoured, other bits are kept
            if (wr_mode && run)
                mode_ff <= {CPU_WDATA[`MODE_RUN_BIT], mode_ff[6:0]};
            else if (wr_mode)
                mode_ff <= CPU_WDATA;
            if (wr_period)
                period_ff <= CPU_WDATA;
            if (wr_dir)
                dir_ff <= CPU_WDATA | `PORT4_DIR_FIXED;
            if (wr_latch)
                latch_ff <= CPU_WDATA;
        end
    end

    // ------------------------------------------------------------
    // duty register with deferred transfer
    // ------------------------------------------------------------
    // a write while counting waits in duty_buf_ff; a write landing on the same cycle as
    // an old-value match is not transferred then, only at the following match
    always @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            duty_ff <= `RST_DUTY;
            duty_buf_ff <= `RST_DUTY;
            duty_pend_ff <= 1'b0;
        end
        else if (wr_duty)
        begin
            duty_buf_ff <= CPU_WDATA;
            if (run)
                duty_pend_ff <= 1'b1;
            else
            begin
                duty_ff <= CPU_WDATA;
                duty_pend_ff <= 1'b0;
            end
        end
        else if (duty_match && duty_pend_ff)
        begin
            duty_ff <= duty_buf_ff;
            duty_pend_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // counter, compare phase and output toggle
    // ------------------------------------------------------------
    always @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            cnt_ff <= 8'h00;
            st_ff <= ST_PERIOD;
            tout_ff <= 1'b0;
        end
        else if (!run)
        begin
            // stop zeroes counter and returns output inactive
            cnt_ff <= 8'h00;
            st_ff <= ST_PERIOD;
            tout_ff <= 1'b0;
        end
        else if (per_match)
        begin
            cnt_ff <= 8'h00;
            if (pwm)
            begin
                tout_ff <= 1'b1;
                st_ff <= ST_DUTY;
            end
            else
                tout_ff <= ~tout_ff;
        end
        else if (duty_match)
        begin
            // duty match never clears, so the count must still advance here
            cnt_ff <= cnt_ff + 8'h01;
            tout_ff <= 1'b0;
            st_ff <= ST_PERIOD;
        end
        else if (tick)
        begin
            cnt_ff <= cnt_ff + 8'h01;
            case (st_ff)
                ST_PERIOD: st_ff <= ST_PERIOD;
                ST_DUTY: st_ff <= ST_DUTY;
                default: st_ff <= ST_PERIOD;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin path
    // ------------------------------------------------------------
    // active level is the inverse of the default level gated by enable
    assign out_lvl = mode_ff[`MODE_OEN_BIT] ? (tout_ff ^ mode_ff[`MODE_LEV_BIT])
                                            : mode_ff[`MODE_LEV_BIT];
    // timer only reaches the pin when software clears direction and latch bits
    assign pin_level = out_lvl & ~latch_ff[`SHARED_PIN_BIT];
    assign pin_oe_n = dir_ff[`SHARED_PIN_BIT];

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always @*
    begin
        case (CPU_ADDR)
            `OFS_TIMER_MODE: nxt_rdata = mode_ff;
            `OFS_PERIOD_COMPARE: nxt_rdata = period_ff;
            `OFS_DUTY_COMPARE: nxt_rdata = duty_buf_ff;
            `OFS_PORT4_DIRECTION: nxt_rdata = dir_ff;
            `OFS_PORT4_LATCH: nxt_rdata = latch_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // irq one REF_CLK cycle per period match; only a match on the stopping edge still shows in the first stopped cycle
    always @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            MATCH_IRQ <= 1'b0;
            TIMER_OUT_PIN <= 1'b0;
            TIMER_OUT_PIN_OE_N <= 1'b1;
            CPU_RDATA <= 8'h00;
            COUNT_VALUE <= 8'h00;
        end
        else
        begin
            MATCH_IRQ <= per_match;
            TIMER_OUT_PIN <= pin_level;
            TIMER_OUT_PIN_OE_N <= pin_oe_n;
            CPU_RDATA <= CPU_RD ? nxt_rdata : 8'h00;
            COUNT_VALUE <= cnt_ff;
        end
    end
endmodule

// >>> timer_h_asserts.sv
// port checker for the timer, with register shadows
// assumes the cpu port is the only path into the registers
`timescale 1ns/1ps
`include "timer_h_map.vh"
module timer_h_asserts
(
    input wire REF_CLK,
    input wire ARST_N,
    input wire LOSC_CLK,
    input wire CPU_WR,
    input wire CPU_RD,
    input wire [15:0] CPU_ADDR,
    input wire [7:0] CPU_WDATA,
    input wire [7:0] CPU_RDATA,
    input wire MATCH_IRQ,
    input wire TIMER_OUT_PIN,
    input wire TIMER_OUT_PIN_OE_N,
    input wire [7:0] COUNT_VALUE
);
    reg [7:0] mode_ff;
    reg [7:0] per_ff;
    reg [7:0] dir_ff;
    reg [7:0] lat_ff;
    reg [8:0] gap_ff;
    reg steady_ff;
    wire run = mode_ff[7];
    wire wr_mode = CPU_WR && CPU_ADDR == `OFS_TIMER_MODE;
    wire wr_per = CPU_WR && CPU_ADDR == `OFS_PERIOD_COMPARE;
    // ----
    // shadows; mode keeps bits 6:0 while running
    // ----
    always @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            mode_ff <= 8'h00;
            per_ff <= 8'h00;
            dir_ff <= 8'hFF;
            lat_ff <= 8'h00;
            gap_ff <= 9'h000;
            steady_ff <= 1'b0;
        end
        else
        begin
            if (wr_mode)
                mode_ff <= run ? {CPU_WDATA[7], mode_ff[6:0]} : CPU_WDATA;
            if (wr_per)
                per_ff <= CPU_WDATA;
            if (CPU_WR && CPU_ADDR == `OFS_PORT4_DIRECTION)
                dir_ff <= CPU_WDATA | 8'hC0;
            if (CPU_WR && CPU_ADDR == `OFS_PORT4_LATCH)
                lat_ff <= CPU_WDATA;
            // gap is only trusted after one full undisturbed interval
            gap_ff <= MATCH_IRQ ? 9'h001 : gap_ff + {8'h00, !gap_ff[8]};
            steady_ff <= (wr_mode || wr_per || !run) ? 1'b0 : (steady_ff || MATCH_IRQ);
        end
    end
    // ----
    // assertions
    // ----
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    sequence s_idle;
        (!run && $stable(mode_ff) && $stable(lat_ff))[*3];
    endsequence
    sequence s_running;
        (run && $stable(lat_ff))[*3];
    endsequence
    a_stop_zero: assert property (s_idle |-> COUNT_VALUE == 8'h00)
        else $error("counter not held at zero");
    a_stop_level: assert property (s_idle |-> TIMER_OUT_PIN == (mode_ff[1] && !lat_ff[2]))
        else $error("stopped pin not at default level");
    a_stop_quiet: assert property ((!run)[*2] |-> !MATCH_IRQ)
        else $error("irq while stopped");
    a_oe_dir: assert property ($stable(dir_ff[2]) |-> TIMER_OUT_PIN_OE_N == dir_ff[2])
        else $error("pin drive does not follow direction");
    a_dir_top: assert property ($past(CPU_RD) && $past(CPU_ADDR) == `OFS_PORT4_DIRECTION
        |-> CPU_RDATA[7:6] == 2'h3)
        else $error("direction top bits not one");
    a_irq_gap: assert property (MATCH_IRQ && steady_ff && mode_ff[6:4] == 3'h0
        |-> gap_ff == {1'b0, per_ff} + 9'h001)
        else $error("irq spacing wrong");
    a_irq_toggle: assert property (MATCH_IRQ && $past(run) && mode_ff[3:2] == `MD_INTERVAL
        && mode_ff[0] && !lat_ff[2] |=> TIMER_OUT_PIN != $past(TIMER_OUT_PIN))
        else $error("pin did not toggle on match");
    a_pin_holds: assert property (s_running ##0 !$past(MATCH_IRQ) && mode_ff[3:2] == `MD_INTERVAL
        |-> $stable(TIMER_OUT_PIN))
        else $error("pin moved between matches");
    a_pwm_on: assert property (MATCH_IRQ && mode_ff[3:2] == `MD_PWM && mode_ff[0]
        && !lat_ff[2] |=> TIMER_OUT_PIN == !mode_ff[1])
        else $error("pwm pin not active on period match");
    a_irq_pulse: assert property (MATCH_IRQ && per_ff != 8'h00 |=> !MATCH_IRQ)
        else $error("irq longer than one cycle");
endmodule
bind timer_h timer_h_asserts i_chk (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .LOSC_CLK(LOSC_CLK),
    .CPU_WR(CPU_WR), .CPU_RD(CPU_RD), .CPU_ADDR(CPU_ADDR), .CPU_WDATA(CPU_WDATA),
    .CPU_RDATA(CPU_RDATA), .MATCH_IRQ(MATCH_IRQ), .TIMER_OUT_PIN(TIMER_OUT_PIN),
    .TIMER_OUT_PIN_OE_N(TIMER_OUT_PIN_OE_N), .COUNT_VALUE(COUNT_VALUE));

// >>> timer_h_map.vh
// constants for the 8-bit interval / pwm timer: offsets, fields, resets, prescaler taps
// assumes inclusion by the timer design, checker and testbench files
`ifndef TIMER_H_MAP_VH
`define TIMER_H_MAP_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFS_PORT4_DIRECTION 16'hFF24
`define OFS_TIMER_MODE 16'hFF70
`define OFS_PERIOD_COMPARE 16'hFF71
`define OFS_DUTY_COMPARE 16'hFF72
`define OFS_PORT4_LATCH 16'hFF73

// ------------------------------------------------------------
// mode register fields
// ------------------------------------------------------------
`define MODE_RUN_BIT 7
`define MODE_CKS_HI 6
`define MODE_CKS_LO 4
`define MODE_MD_HI 3
`define MODE_MD_LO 2
`define MODE_LEV_BIT 1
`define MODE_OEN_BIT 0
`define MD_INTERVAL 2'h0
`define MD_PWM 2'h2

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_MODE 8'h00
`define RST_PERIOD 8'h00
`define RST_DUTY 8'h00
`define RST_PORT4_DIR 8'hFF
`define RST_PORT4_LATCH 8'h00
`define PORT4_DIR_FIXED 8'hC0
`define SHARED_PIN_BIT 2

// ------------------------------------------------------------
// prescaler taps: divide by 1,4,16,64,4096 of the peripheral clock; 128 of low-speed osc
// ------------------------------------------------------------
`define PRE_WIDTH 12
`define LOSC_DIV_WIDTH 7
`define CKS_DIV1 3'h0
`define CKS_DIV4 3'h1
`define CKS_DIV16 3'h2
`define CKS_DIV64 3'h3
`define CKS_DIV4096 3'h4
`define CKS_LOSC128 3'h5

`endif

// >>> timer_h_prescaler.v
// count-clock prescaler: one-cycle tick per selected count clock period
// assumes the low-speed oscillator already sits as a level in the REF_CLK domain
`timescale 1ns/1ps
`include "timer_h_map.vh"

module timer_h_prescaler
(
    input wire clk,
    input wire arst_n,
    input wire run,
    input wire [2:0] clk_sel,
    input wire losc_sync,
    output reg tick_ff
)
;
    reg [`PRE_WIDTH-1:0] pre_ff;
    reg [`LOSC_DIV_WIDTH-1:0] losc_cnt_ff;
    reg losc_prev_ff;
    reg nxt_tick;
    wire losc_rise;
    wire [`PRE_WIDTH-1:0] pre_inc;

    assign losc_rise = losc_sync & ~losc_prev_ff;
    assign pre_inc = pre_ff + {{(`PRE_WIDTH-1){1'b0}}, 1'b1};

    // ------------------------------------------------------------
    // tap select; divider restarts with run so first tick lands at most one count clock after start
    // ------------------------------------------------------------
    always @*
    begin
        case (clk_sel)
            `CKS_DIV1: nxt_tick = 1'b1;
            `CKS_DIV4: nxt_tick = (pre_ff[1:0] == 2'h3);
            `CKS_DIV16: nxt_tick = (pre_ff[3:0] == 4'hF);
            `CKS_DIV64: nxt_tick = (pre_ff[5:0] == 6'h3F);
            `CKS_DIV4096: nxt_tick = (pre_ff == 12'hFFF);
            `CKS_LOSC128: nxt_tick = losc_rise && (losc_cnt_ff == 7'h7F);
            default: nxt_tick = 1'b0; // prohibited codes: timer frozen
        endcase
    end

    // counters clear while stopped
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pre_ff <= 12'h000;
            losc_cnt_ff <= 7'h00;
            losc_prev_ff <= 1'b0;
            tick_ff <= 1'b0;
        end
        else
        begin
            losc_prev_ff <= losc_sync;
            if (!run)
            begin
                pre_ff <= 12'h000;
                losc_cnt_ff <= 7'h00;
                tick_ff <= 1'b0;
            end
            else
            begin
                pre_ff <= pre_inc;
                if (losc_rise)
                    losc_cnt_ff <= losc_cnt_ff + 7'h01;
                tick_ff <= nxt_tick;
            end
        end
    end
endmodule
